// file: emb_ram.sv
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module emb_ram (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // User memory port
  input  wire logic                        mem_ce,
  input  wire logic                        mem_we,
  input  wire logic [emb_pkg::ADDR_W-1:0]  mem_addr,
  input  wire logic [emb_pkg::WORD_W-1:0]  write_data_in,
  input  wire logic [2:0]                  bank_sel,
  input  wire logic                        mem_rst,
  input  wire logic                        global_set_reset,
  output wire logic [emb_pkg::WORD_W-1:0]  read_data_out,
  output wire logic [1:0]                  err_status,
  // AXI4-Lite write
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output wire logic                        s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output wire logic                        s_axi_wready,
  output wire logic [1:0]                  s_axi_bresp,
  output wire logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output wire logic                        s_axi_arready,
  output wire logic [31:0]                 s_axi_rdata,
  output wire logic [1:0]                  s_axi_rresp,
  output wire logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Interrupt
  output wire logic                        irq
);

  // ******************************************************************
  // Register bus
  // ******************************************************************
  emb_pkg::emb_cfg_t cfg_reg;
  logic [1:0]        sts_reg;
  logic [1:0]        msk_reg;
  logic [31:0]       inj_reg;
  logic              aw_ok_reg;
  logic              w_ok_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        ev;
  logic              wr_step;

  wire aw_go = s_axi_awvalid && s_axi_awready;
  wire w_go  = s_axi_wvalid && s_axi_wready;
  wire wr_do = (aw_ok_reg || aw_go) && (w_ok_reg || w_go);
  wire [7:0]  wa = aw_ok_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd = w_ok_reg ? w_data_reg : s_axi_wdata;
  wire [3:0]  ws = w_ok_reg ? w_strb_reg : s_axi_wstrb;
  wire [31:0] wm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire wr_hit = wa inside {emb_pkg::CTRL_OFF, emb_pkg::STATUS_OFF,
    emb_pkg::MASK_OFF, emb_pkg::INJECT_OFF, emb_pkg::ERRSTAT_OFF};

  assign s_axi_awready = !aw_ok_reg && !bvalid_reg;
  assign s_axi_wready  = !w_ok_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq           = |(sts_reg & msk_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_ok_reg   <= 1'b0;
      w_ok_reg    <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= emb_pkg::RESP_OKAY;
    end else if (wr_do) begin
      aw_ok_reg  <= 1'b0;
      w_ok_reg   <= 1'b0;
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? emb_pkg::RESP_OKAY : emb_pkg::RESP_SLVERR;
    end else begin
      if (aw_go) begin
        aw_ok_reg   <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_go) begin
        w_ok_reg   <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= emb_pkg::CFG_RST;
      msk_reg <= 2'h0;
    end else if (wr_do && wa == emb_pkg::CTRL_OFF) begin
      cfg_reg <= emb_pkg::emb_cfg_t'((32'(cfg_reg) & ~wm) | (wd & wm));
    end else if (wr_do && wa == emb_pkg::MASK_OFF) begin
      msk_reg <= (msk_reg & ~wm[1:0]) | (wd[1:0] & wm[1:0]);
    end
  end

  // Set wins over a same-cycle one-to-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sts_reg <= 2'h0;
    end else if (wr_do && wa == emb_pkg::STATUS_OFF) begin
      sts_reg <= (sts_reg & ~(wd[1:0] & wm[1:0])) | ev;
    end else begin
      sts_reg <= sts_reg | ev;
    end
  end

  // Flip mask applied to the next stored word, then dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inj_reg <= 32'h0000_0000;
    end else if (wr_do && wa == emb_pkg::INJECT_OFF) begin
      inj_reg <= (inj_reg & ~wm) | (wd & wm);
    end else if (wr_step) begin
      inj_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= emb_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= emb_pkg::RESP_OKAY;
      case (s_axi_araddr)
        emb_pkg::CTRL_OFF:    rdata_reg <= 32'(cfg_reg);
        emb_pkg::STATUS_OFF:  rdata_reg <= {30'h0000_0000, sts_reg};
        emb_pkg::MASK_OFF:    rdata_reg <= {30'h0000_0000, msk_reg};
        emb_pkg::INJECT_OFF:  rdata_reg <= inj_reg;
        emb_pkg::ERRSTAT_OFF: rdata_reg <= {30'h0000_0000, err_status};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= emb_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ******************************************************************
  // Input register
  // ******************************************************************
  emb_pkg::emb_req_t req_reg;
  wire clr = mem_rst || (global_set_reset && cfg_reg.gsr_en);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_reg <= '0;
    end else if (clr) begin
      req_reg <= '0;
    end else if (mem_ce) begin
      req_reg.act  <= bank_sel == cfg_reg.decode;
      req_reg.we   <= mem_we;
      req_reg.addr <= mem_addr;
      req_reg.data <= write_data_in;
    end
  end

  // ******************************************************************
  // Array access
  // ******************************************************************
  logic [emb_pkg::WORD_W-1:0] mem_arr [emb_pkg::WORDS];
  logic [emb_pkg::CHK_W-1:0]  chk_arr [emb_pkg::WORDS];
  logic [emb_pkg::WORD_W-1:0] lat_reg;
  logic [emb_pkg::WORD_W-1:0] out_reg;
  logic [1:0]                 lat_err_reg;
  logic [1:0]                 out_err_reg;

  wire        step = mem_ce && !clr && req_reg.act;
  wire [2:0]  lb   = emb_pkg::emb_lane_bits(cfg_reg.shape);
  wire [5:0]  lw   = emb_pkg::emb_lane_w(cfg_reg.shape);
  wire [8:0]  idx  = 9'(req_reg.addr >> lb);
  wire [13:0] lane = req_reg.addr & ((14'h0001 << lb) - 14'h0001);
  wire [5:0]  off  = 6'(lane[4:0] * lw);
  wire [35:0] lmask = 36'((37'h0_0000_0001 << lw) - 37'h0_0000_0001);
  wire [35:0] wmask = lmask << off;
  wire [35:0] raw  = mem_arr[idx];
  wire emb_pkg::emb_dec_t dec = emb_pkg::emb_ecc_dec(raw, chk_arr[idx]);
  wire [35:0] cur  = cfg_reg.ecc_en ? dec.data : raw;
  wire [1:0]  cerr = cfg_reg.ecc_en ? dec.err : 2'b00;
  wire [35:0] old_lane = (cur >> off) & lmask;
  wire [35:0] new_word = (cur & ~wmask) | ((req_reg.data << off) & wmask);
  wire rpt = step && (!req_reg.we ||
    cfg_reg.wmode == emb_pkg::read_before_write_mode);

  assign wr_step = step && req_reg.we;
  assign ev = rpt ? cerr : 2'b00;

  // Contents carry no reset
  always_ff @(posedge clk) begin
    if (wr_step) begin
      mem_arr[idx] <= new_word ^ {4'h0, inj_reg};
      chk_arr[idx] <= emb_pkg::emb_ecc_gen(new_word);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_reg     <= '0;
      lat_err_reg <= 2'b00;
    end else if (clr) begin
      lat_reg     <= '0;
      lat_err_reg <= 2'b00;
    end else if (rpt) begin
      lat_reg     <= old_lane;
      lat_err_reg <= cerr;
    end else if (wr_step &&
        cfg_reg.wmode == emb_pkg::write_through_mode) begin
      lat_reg     <= req_reg.data & lmask;
      lat_err_reg <= 2'b00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_reg     <= '0;
      out_err_reg <= 2'b00;
    end else if (clr) begin
      out_reg     <= '0;
      out_err_reg <= 2'b00;
    end else if (mem_ce) begin
      out_reg     <= lat_reg;
      out_err_reg <= lat_err_reg;
    end
  end

  wire oreg = cfg_reg.omode == emb_pkg::registered_output_mode;
  assign read_data_out = oreg ? out_reg : lat_reg;
  assign err_status = oreg ? out_err_reg : lat_err_reg;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_capture;
    mem_ce && !clr;
  endsequence
  sequence s_write(emb_pkg::emb_wmode_t m);
    wr_step && cfg_reg.wmode == m;
  endsequence
  sequence s_report(logic [1:0] e);
    rpt && cfg_reg.ecc_en && dec.err == e;
  endsequence
  sequence s_cleared;
    !req_reg.act && lat_reg == '0 && out_reg == '0 && err_status == 2'b00;
  endsequence

  AST_INPUT_CAPTURE: assert property (s_capture |=>
    req_reg.addr == $past(mem_addr) && req_reg.data == $past(write_data_in))
    else $error("Input register missed address or data");
  AST_REGISTERED_OUTPUT_MODE_DELAY: assert property (s_capture ##1
    (oreg && $stable(cfg_reg)) |-> read_data_out == $past(lat_reg))
    else $error("Registered output not one clock behind array");
  AST_RESET_CLEARS: assert property (mem_rst |=>
    s_cleared)
    else $error("Register reset left a register set");
  AST_BANK_MISS: assert property (mem_ce && !clr &&
    bank_sel != cfg_reg.decode |=> !req_reg.act)
    else $error("Block answered a foreign bank");
  AST_HOLD_NO_CE: assert property (!mem_ce && !clr |=>
    $stable(lat_reg) && $stable(req_reg) && $stable(out_reg))
    else $error("Register moved with clock enable low");
  AST_NORMAL_HOLD: assert property (s_write(emb_pkg::normal_mode) |=>
    $stable(lat_reg))
    else $error("Normal write disturbed read output");
  AST_WRITE_THROUGH: assert property (
    s_write(emb_pkg::write_through_mode) |=>
    lat_reg == $past(req_reg.data & lmask))
    else $error("Write-through did not show new data");
  AST_READ_BEFORE: assert property (
    s_write(emb_pkg::read_before_write_mode) |=>
    lat_reg == $past(old_lane))
    else $error("Read-before-write did not show old data");
  AST_CLEAN_WORD: assert property (s_report(2'b00) |=>
    lat_err_reg == 2'b00)
    else $error("Clean word reported an error");
  AST_SINGLE_FIX: assert property (s_report(2'b01) |=>
    lat_err_reg == 2'b01 && sts_reg[0] ##1 irq || !msk_reg[0])
    else $error("Single-bit error not flagged");
  AST_DOUBLE_FLAG: assert property (s_report(2'b10) |=>
    lat_err_reg == 2'b10 && sts_reg[1])
    else $error("Double-bit error not flagged");
  AST_GSR_IGNORED: assert property (global_set_reset &&
    !cfg_reg.gsr_en && !mem_rst && mem_ce |=>
    req_reg.addr == $past(mem_addr))
    else $error("Disabled global reset acted");

  // Clears, banks, lanes and the error path
  AST_GSR_ACTS: assert property (global_set_reset &&
    cfg_reg.gsr_en |=> s_cleared)
    else $error("Enabled global reset did not clear");
  AST_BANK_HIT: assert property (mem_ce && !clr &&
    bank_sel == cfg_reg.decode |=> req_reg.act)
    else $error("Block ignored its own bank");
  AST_BANK_KEEPS: assert property (mem_ce &&
    !clr && !req_reg.act |=> $stable(lat_reg))
    else $error("Foreign bank access moved the output");
  AST_CODING_OFF: assert property (rpt && !cfg_reg.ecc_en |=>
    lat_err_reg == 2'b00)
    else $error("Error reported with coding off");
  AST_LANE_ONLY: assert property (rpt |=>
    (lat_reg & ~$past(lmask)) == '0)
    else $error("Read output carries bits beyond its lane");
  AST_OUT_ERR_DELAY: assert property (s_capture ##1
    (oreg && $stable(cfg_reg)) |-> err_status == $past(lat_err_reg))
    else $error("Registered error status not one clock behind");
  AST_HOLD_ERR: assert property (!mem_ce && !clr |=>
    $stable(lat_err_reg) && $stable(out_err_reg))
    else $error("Error status moved with clock enable low");
  AST_STATUS_STICKY: assert property (sts_reg[1] &&
    !(wr_do && wa == emb_pkg::STATUS_OFF && wd[1] && wm[1]) |=>
    sts_reg[1])
    else $error("Uncorrectable flag dropped without a clear");
  AST_WRITE_STORED: assert property (wr_step && inj_reg == '0 |=>
    ((mem_arr[$past(idx)] >> $past(off)) & $past(lmask)) ==
    $past(req_reg.data & lmask))
    else $error("Written lane not found in the array");

endmodule // emb_ram

// file: emb_pkg.sv
// What this block does
// - Address and write data registered before array
// - Optional output register adds one clock
// - Register reset clears registers, not contents
// - Respond only when bank select matches decode
// - Array holds 18,432 bits in x9, x18 and x36 shapes, 16,384 in x1, x2 and x4
// - Six depth by width shapes, x1 default
// - Three write modes, normal by default
// - Coding on: status 00 means clean word
// - Single-bit error corrected, low status bit
// - Double-bit error flagged, high status bit
// - Global set/reset acts only when enabled
package emb_pkg;

  // ******************************************************************
  // Array geometry and bus map
  // ******************************************************************
  localparam int MEM_BITS = 18432;
  localparam int WORD_W   = 36;
  localparam int WORDS    = MEM_BITS / WORD_W;
  localparam int ADDR_W   = 14;
  localparam int CHK_W    = 7;

  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] MASK_OFF   = 8'h08;
  localparam logic [7:0] INJECT_OFF = 8'h0C;
  localparam logic [7:0] ERRSTAT_OFF = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [1:0] {
    normal_mode            = 2'b00,
    write_through_mode     = 2'b01,
    read_before_write_mode = 2'b10
  } emb_wmode_t;

  typedef enum logic {
    unregistered_output_mode = 1'b0,
    registered_output_mode   = 1'b1
  } emb_omode_t;

  typedef struct packed {
    logic       gsr_en;
    logic       ecc_en;
    logic [2:0] decode;
    emb_wmode_t wmode;
    emb_omode_t omode;
    logic [2:0] shape;
  } emb_cfg_t;

  typedef struct packed {
    logic              act;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } emb_req_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic [1:0]        err;
  } emb_dec_t;

  localparam emb_cfg_t CFG_RST = '{gsr_en: 1'b1, ecc_en: 1'b0,
    decode: 3'h0, wmode: normal_mode, omode: unregistered_output_mode,
    shape: 3'h0};

  // ******************************************************************
  // Shape and check-code functions
  // ******************************************************************
  function automatic logic [2:0] emb_lane_bits(input logic [2:0] s);
    case (s)
      3'h0:    return 3'h5;
      3'h1:    return 3'h4;
      3'h2:    return 3'h3;
      3'h3:    return 3'h2;
      3'h4:    return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [5:0] emb_lane_w(input logic [2:0] s);
    case (s)
      3'h0:    return 6'h01;
      3'h1:    return 6'h02;
      3'h2:    return 6'h04;
      3'h3:    return 6'h09;
      3'h4:    return 6'h12;
      default: return 6'h24;
    endcase
  endfunction

  // Distinct syndrome per data bit, never a single set bit
  function automatic logic [5:0] emb_code(input int i);
    return (i < 8) ? 6'(i + 24) : 6'(i + 25);
  endfunction

  function automatic logic [CHK_W-1:0] emb_ecc_gen(
      input logic [WORD_W-1:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < WORD_W; i++) begin
      if (d[i]) begin
        c = c ^ emb_code(i);
      end
    end
    return {^{d, c}, c};
  endfunction

  function automatic emb_dec_t emb_ecc_dec(input logic [WORD_W-1:0] d,
      input logic [CHK_W-1:0] k);
    emb_dec_t r;
    logic [5:0] syn;
    logic       odd;
    logic [CHK_W-1:0] g;
    g = emb_ecc_gen(d);
    syn = k[5:0] ^ g[5:0];
    odd = ^{d, k};
    r.data = d;
    r.err = 2'b00;
    if (odd) begin
      r.err = 2'b01;
      for (int i = 0; i < WORD_W; i++) begin
        if (syn == emb_code(i)) begin
          r.data[i] = ~d[i];
        end
      end
    end else if (syn != 6'h00) begin
      r.err = 2'b10;
    end
    return r;
  endfunction

endpackage

// file: emb_user.sv
`timescale 1ns/10ps
// ******************************************************************
// User logic that drives the memory port from the fabric
// ******************************************************************
module emb_user (
  // Clock
  input  wire logic                        clk,
  // Memory port
  output logic                             mem_ce,
  output logic                             mem_we,
  output logic [emb_pkg::ADDR_W-1:0]       mem_addr,
  output logic [emb_pkg::WORD_W-1:0]       write_data_in,
  output logic [2:0]                       bank_sel
);
  initial begin
    mem_ce = 1'b0;
    mem_we = 1'b0;
    mem_addr = '0;
    write_data_in = '0;
    bank_sel = '0;
  end

  // One access; the flat address carries the bank in its top bits
  task automatic req(input logic w, input logic [16:0] fa,
      input logic [35:0] d);
    @(posedge clk);
    mem_ce <= 1'b1;
    mem_we <= w;
    mem_addr <= fa[13:0];
    bank_sel <= fa[16:14];
    write_data_in <= d;
    @(posedge clk);
    mem_we <= 1'b0;
    write_data_in <= ~d;
  endtask

  // Clock enable low with a write pending that must be ignored
  task automatic hold(input int n, input logic [35:0] d);
    @(posedge clk);
    mem_ce <= 1'b0;
    mem_we <= 1'b1;
    write_data_in <= d;
    repeat (n) @(posedge clk);
    mem_ce <= 1'b1;
    mem_we <= 1'b0;
    write_data_in <= ~d;
  endtask
endmodule // emb_user

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ******************************************************************
  // Signals and model state
  // ******************************************************************
  logic        clk, rst, mem_rst, global_set_reset, irq, om, lv;
  logic        mem_ce, mem_we;
  logic [13:0] mem_addr;
  logic [35:0] write_data_in, read_data_out, last;
  logic [2:0]  bank_sel, dec;
  logic [1:0]  err_status, wm, exp_err, s_axi_bresp, s_axi_rresp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [35:0] m [int];
  int          n_mismatch, tests_run, lw;
  int          wd [8] = '{1, 2, 4, 9, 18, 36, 36, 36};

  emb_ram emb_ram_inst (.clk, .rst, .mem_ce, .mem_we, .mem_addr,
    .write_data_in, .bank_sel, .mem_rst, .global_set_reset,
    .read_data_out, .err_status, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  emb_user emb_user_inst (.clk, .mem_ce, .mem_we, .mem_addr,
    .write_data_in, .bank_sel);

  always #5 clk = ~clk;

  // ******************************************************************
  // Compares, bus cycles and model
  // ******************************************************************
  task automatic chk_d(input logic [35:0] g, input logic [35:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_r(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [35:0] rnd();
    return 36'({$urandom(), $urandom()});
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b0;
    chk_r({30'h0, s_axi_bresp}, {30'h0, e});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk_r(s_axi_rdata, e);
    chk_r({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic cfg(input logic [31:0] v);
    axi_wr(8'h00, v, 2'h0);
    om = v[3];
    wm = v[5:4];
    dec = v[8:6];
    lw = wd[v[2:0]];
  endtask

  // Model access: expected output per write mode and bank match
  task automatic mop(input logic w, input int a, input logic [35:0] d);
    logic [35:0] e, k;
    logic        hit;
    k = d & 36'((37'h1 << lw) - 37'h1);
    hit = (a >> 14) == dec;
    e = last;
    if (hit && !w) e = m[a];
    if (hit && w && wm == 2'h1) e = k;
    if (hit && w && wm == 2'h2) e = m[a];
    if (hit && w) m[a] = k;
    emb_user_inst.req(w, 17'(a), d);
    @(posedge clk);
    if (om) @(posedge clk);
    #1;
    if ((lv || !w) && exp_err != 2'h2) chk_d(read_data_out, e);
    if (!w) chk_d({34'h0, err_status}, {34'h0, exp_err});
    if (hit) last = m[a];
    if (hit) lv = 1'b1;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial begin
    #500000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    void'($urandom(25276));
    clk = 1'b0;
    rst = 1'b1;
    mem_rst = 1'b0;
    global_set_reset = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    last = '0;
    lv = 1'b1;
    exp_err = 2'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axi_rd(8'h00, 32'h0000_0400, 2'h0);
    axi_rd(8'h08, 32'h0000_0000, 2'h0);
    axi_rd(8'h20, 32'h0000_0000, emb_pkg::RESP_SLVERR);
    axi_wr(8'h20, 32'h0000_0001, emb_pkg::RESP_SLVERR);
    $display("test registers done");
    for (int s = 0; s < 6; s++) begin
      cfg(32'h0000_0400 | 32'(s));
      m.delete();
      lv = 1'b0;
      for (int i = 0; i < 6; i++)
        mop(i < 3, i % 3 == 2 ? (32'h4000 >> s) - 1 : i % 3, rnd());
    end
    $display("test shapes done");
    for (int i = 0; i < 6; i++) begin
      cfg(32'h0000_0405 | 32'((i % 2) << 3) | 32'((i / 2) << 4));
      mop(1'b1, 9, rnd());
      mop(1'b0, 9, 36'h0);
      mop(1'b1, 9, rnd());
      mop(1'b0, 9, 36'h0);
    end
    $display("test write modes done");
    cfg(32'h0000_0545);
    mop(1'b1, 5 << 14 | 3, rnd());
    mop(1'b1, 2 << 14 | 3, rnd());
    mop(1'b0, 2 << 14 | 3, 36'h0);
    mop(1'b0, 5 << 14 | 3, 36'h0);
    emb_user_inst.hold(3, rnd());
    #1 chk_d(read_data_out, last);
    mop(1'b0, 5 << 14 | 3, 36'h0);
    for (int g = 0; g < 3; g++) begin
      if (g == 2) cfg(32'h0000_0145);
      @(posedge clk);
      if (g == 0) mem_rst <= 1'b1;
      else global_set_reset <= 1'b1;
      @(posedge clk);
      mem_rst <= 1'b0;
      global_set_reset <= 1'b0;
      #1 chk_d(read_data_out, g == 2 ? last : 36'h0);
      mop(1'b0, 5 << 14 | 3, 36'h0);
    end
    $display("test bank and clears done");
    cfg(32'h0000_0605);
    for (int j = 1; j <= 2; j++) begin
      axi_wr(8'h08, j == 1 ? 32'h3 : 32'h1, 2'h0);
      mop(1'b1, 21, rnd());
      // Flip lands on the next stored word, so word 20 goes last
      axi_wr(8'h0C, j == 1 ? 32'h1 : 32'h3, 2'h0);
      mop(1'b1, 20, rnd());
      exp_err = 2'(j);
      mop(1'b0, 20, 36'h0);
      axi_rd(8'h10, 32'(j), 2'h0);
      exp_err = 2'h0;
      mop(1'b0, 21, 36'h0);
      #1 chk_r({31'h0, irq}, 32'(j == 1));
      axi_rd(8'h04, 32'(j), 2'h0);
      axi_wr(8'h04, 32'(j), 2'h0);
      axi_rd(8'h04, 32'h0, 2'h0);
      #1 chk_r({31'h0, irq}, 32'h0);
    end
    $display("test error coding done");
    finish_test;
  end
endmodule // tb_top
